// ### logic/dtp_params.svh
// Register map, field positions, reset values and counts of the dual 8-bit timer block.
// Assumes a byte-wide register file behind a 32-bit AXI4-Lite slave, index times four.
`ifndef DTP_PARAMS_SVH
`define DTP_PARAMS_SVH
`define DTP_IDX_CMP2        6'h23
`define DTP_IDX_CNT2        6'h24
`define DTP_IDX_T2CTRL      6'h25
`define DTP_IDX_ASYNC       6'h30
`define DTP_IDX_CMP0        6'h31
`define DTP_IDX_CNT0        6'h32
`define DTP_IDX_T0CTRL      6'h33
`define DTP_IDX_SLEEP       6'h35
`define DTP_IDX_FLAG        6'h36
`define DTP_IDX_MASK        6'h37
`define DTP_BIT_OVF0        0
`define DTP_BIT_CMP0        1
`define DTP_BIT_OVF2        6
`define DTP_BIT_CMP2        7
`define DTP_BIT_ASYNC_SEL   0
`define DTP_BIT_SLEEP_ENTER 7
`define DTP_CTRL_WMASK      8'h7f
`define DTP_REG_RST         8'h00
`define DTP_WAKE_EXT_CYC    2'h2
`define DTP_WAKE_TMR_CYC    2'h3
`define DTP_SM_PDOWN        2'h2
`define DTP_SM_PSAVE        2'h3
`define DTP_CS_STOP         3'h0
`define DTP_CS_EXT_FALL     3'h6
`define DTP_CS_EXT_RISE     3'h7
`define DTP_RESP_OKAY       2'h0
`define DTP_RESP_SLVERR     2'h2
`endif

// ### logic/dtp_pkg.sv
// Types shared by the dual 8-bit timer block.
// Assumes the constants header is included by each user.
package dtp_pkg;
  typedef struct packed {
    logic       reserved;
    logic       pwm;
    logic [1:0] com;
    logic       ctc;
    logic [2:0] cs;
  } dtp_tctrl_t;
  typedef enum logic [1:0] {
    DTP_COM_OFF    = 2'h0,
    DTP_COM_TOGGLE = 2'h1,
    DTP_COM_CLEAR  = 2'h2,
    DTP_COM_SET    = 2'h3
  } dtp_com_t;
  typedef enum logic [2:0] {
    DTP_ST_RUN   = 3'h1,
    DTP_ST_SLEEP = 3'h2,
    DTP_ST_HIDE  = 3'h4
  } dtp_state_t;
endpackage

// ### logic/dtp_sync.sv
// Two-flop synchroniser for one pin level.
// Assumes the pin is slow compared with aclk.
`timescale 1ns/100ps
module dtp_sync (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // Level
  input  wire logic pin_in,
  output logic      sync_out
);
  logic meta_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else if (ce) begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end
endmodule // dtp_sync

// ### logic/dtp_timer8.sv
// One 8-bit timer with compare, clear-on-match, pin action and up/down PWM.
// Assumes tick is a one-cycle count enable already prescaled by the parent.
`timescale 1ns/100ps
module dtp_timer8 import dtp_pkg::*; (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Control
  input  wire dtp_tctrl_t ctrl,
  input  wire logic [7:0] cmp_val,
  input  wire logic       tick,
  input  wire logic       cnt_wr,
  input  wire logic [7:0] cnt_wdata,
  // Status
  output logic [7:0]      cnt_reg,
  output logic            pin_reg,
  output logic            ovf,
  output logic            match
);
  logic [7:0] cnt_next;
  logic [7:0] cmp_buf_reg;
  logic       dir_down_reg;
  logic       counted_reg;
  wire  [7:0] cmp_eff  = ctrl.pwm ? cmp_buf_reg : cmp_val;
  wire        at_top   = cnt_reg == 8'hff;
  wire        at_bot   = cnt_reg == 8'h00;
  wire        ctc_clr  = match && ctrl.ctc && !ctrl.pwm;
  wire        tick_ok  = tick && !cnt_wr && !ctc_clr;
  // A software write never counts as reaching the compare value.
  assign match = counted_reg && (cnt_reg == cmp_eff);
  assign ovf   = tick_ok && (ctrl.pwm ? (dir_down_reg && at_bot) : at_top);
  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_wr) begin
      cnt_next = cnt_wdata;
    end else if (ctc_clr) begin
      cnt_next = 8'h00;
    end else if (tick && !ctrl.pwm) begin
      cnt_next = cnt_reg + 8'h01;
    end else if (tick && dir_down_reg) begin
      cnt_next = at_bot ? 8'h01 : cnt_reg - 8'h01;
    end else if (tick) begin
      cnt_next = at_top ? 8'hfe : cnt_reg + 8'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg      <= 8'h00;
      cmp_buf_reg  <= 8'h00;
      dir_down_reg <= 1'b0;
      counted_reg  <= 1'b0;
    end else if (ce) begin
      cnt_reg     <= cnt_next;
      counted_reg <= tick_ok;
      // In PWM mode the compare is latched only at the top so an unsynchronised write cannot glitch.
      cmp_buf_reg <= (!ctrl.pwm || at_top) ? cmp_val : cmp_buf_reg;
      if (!ctrl.pwm) begin
        dir_down_reg <= 1'b0;
      end else if (tick_ok && at_top) begin
        dir_down_reg <= 1'b1;
      end else if (tick_ok && at_bot) begin
        dir_down_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_reg <= 1'b0;
    end else if (ce && match) begin
      if (ctrl.pwm && ctrl.com[1]) begin
        pin_reg <= dir_down_reg ^ ctrl.com[0];
      end else if (!ctrl.pwm) begin
        unique case (dtp_com_t'(ctrl.com))
          DTP_COM_OFF:    pin_reg <= pin_reg;
          DTP_COM_TOGGLE: pin_reg <= !pin_reg;
          DTP_COM_CLEAR:  pin_reg <= 1'b0;
          DTP_COM_SET:    pin_reg <= 1'b1;
        endcase
      end
    end
  end
endmodule // dtp_timer8

// ### logic/dtp_top.sv
// Dual 8-bit timer block: prescalers, two timers, flags, mask, sleep wake and AXI4-Lite slave.
// Assumes one 10 MHz clock; the oscillator, count and wake pins arrive asynchronously.
`timescale 1ns/100ps
`include "dtp_params.svh"
module dtp_top import dtp_pkg::*; (
  // Clock, reset and freeze
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins
  input  wire logic        async_osc_in_pin,
  input  wire logic        ext_count_pin,
  input  wire logic        ext_wake_pin,
  output logic             compare_out_pin_0,
  output logic             compare_out_pin_2,
  // System
  output logic             irq,
  output logic             wake_pulse,
  output logic             sleeping
);
  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx == `DTP_IDX_CMP2)  || (idx == `DTP_IDX_CNT2) ||
                (idx == `DTP_IDX_T2CTRL) || (idx == `DTP_IDX_ASYNC) ||
                (idx == `DTP_IDX_CMP0)  || (idx == `DTP_IDX_CNT0) ||
                (idx == `DTP_IDX_T0CTRL) || (idx == `DTP_IDX_SLEEP) ||
                (idx == `DTP_IDX_FLAG)  || (idx == `DTP_IDX_MASK);
  endfunction
  // Low bits of a prescaler all ones marks the tap; n equal to zero passes every tick.
  function automatic logic tap_hit(input logic [9:0] c, input logic [3:0] n);
    logic [9:0] msk;
    msk     = (10'h001 << n) - 10'h001;
    tap_hit = (c & msk) == msk;
  endfunction
  function automatic logic [3:0] t0_div(input logic [2:0] cs);
    unique case (cs)
      3'h1:    t0_div = 4'h0;
      3'h2:    t0_div = 4'h3;
      3'h3:    t0_div = 4'h5;
      3'h4:    t0_div = 4'h6;
      3'h5:    t0_div = 4'h7;
      3'h6:    t0_div = 4'h8;
      3'h7:    t0_div = 4'ha;
      default: t0_div = 4'h0;
    endcase
  endfunction
  function automatic logic [3:0] t2_div(input logic [2:0] cs);
    unique case (cs)
      3'h1:    t2_div = 4'h0;
      3'h2:    t2_div = 4'h3;
      3'h3:    t2_div = 4'h6;
      3'h4:    t2_div = 4'h8;
      3'h5:    t2_div = 4'ha;
      default: t2_div = 4'h0;
    endcase
  endfunction

  // Register state.
  dtp_tctrl_t t0ctrl_reg;
  dtp_tctrl_t t2ctrl_reg;
  logic [7:0] cmp0_reg;
  logic [7:0] cmp2_reg;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [7:0] mask_reg;
  logic       async_sel_reg;
  logic [1:0] sleep_mode_select_reg;
  dtp_state_t state_reg;
  dtp_state_t state_next;
  logic [1:0] hide_cnt_reg;
  logic [1:0] hide_cnt_next;
  logic [9:0] pre0_reg;
  logic [9:0] pre2_reg;
  logic       osc_d_reg;
  logic       ext_d_reg;

  // Bus slave state.
  logic       aw_have_reg;
  logic [5:0] aw_idx_reg;
  logic       w_have_reg;
  logic [7:0] w_data_reg;
  logic       w_lane_reg;

  // Pin synchronisers.
  logic osc_sync;
  logic ext_sync;
  logic wake_sync;
  dtp_sync u_sync_osc (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .pin_in   (async_osc_in_pin),
    .sync_out (osc_sync)
  );
  dtp_sync u_sync_ext (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .pin_in   (ext_count_pin),
    .sync_out (ext_sync)
  );
  dtp_sync u_sync_wake (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .pin_in   (ext_wake_pin),
    .sync_out (wake_sync)
  );

  // Bus decode.
  wire        aw_take = s_axi_awvalid && s_axi_awready;
  wire        w_take  = s_axi_wvalid && s_axi_wready;
  wire        ar_take = s_axi_arvalid && s_axi_arready;
  wire        do_wr   = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire        wr_ok   = do_wr && w_lane_reg && is_mapped(aw_idx_reg);
  wire [5:0]  ar_idx  = s_axi_araddr[7:2];
  wire        ar_ok   = is_mapped(ar_idx) && (s_axi_araddr[1:0] == 2'h0);
  wire        aw_have_next = (aw_have_reg || aw_take) && !do_wr;
  wire        w_have_next  = (w_have_reg || w_take) && !do_wr;
  wire        bvalid_next  = do_wr || (s_axi_bvalid && !s_axi_bready);
  wire        wr_t0ctrl = wr_ok && (aw_idx_reg == `DTP_IDX_T0CTRL);
  wire        wr_t2ctrl = wr_ok && (aw_idx_reg == `DTP_IDX_T2CTRL);
  wire        wr_cnt0   = wr_ok && (aw_idx_reg == `DTP_IDX_CNT0);
  wire        wr_cnt2   = wr_ok && (aw_idx_reg == `DTP_IDX_CNT2);
  wire        wr_flag   = wr_ok && (aw_idx_reg == `DTP_IDX_FLAG);
  wire        wr_sleep  = wr_ok && (aw_idx_reg == `DTP_IDX_SLEEP);
  wire        visible   = state_reg != DTP_ST_HIDE;
  wire        rd_flag   = ar_take && (ar_idx == `DTP_IDX_FLAG) && visible;

  // Sleep gating: power-down stops both timers, power-save keeps only an async timer 0.
  wire deep   = state_reg == DTP_ST_SLEEP && sleep_mode_select_reg[1];
  wire psave  = sleep_mode_select_reg == `DTP_SM_PSAVE;
  // A synchronous timer 0 simply freezes in power-save; software must treat it as stale.
  wire t0_run = !deep || (psave && async_sel_reg);
  wire t2_run = !deep;

  // Prescalers and tick selection.
  wire       osc_rise = osc_sync && !osc_d_reg;
  wire       src0     = async_sel_reg ? osc_rise : 1'b1;
  wire       ext_rise = ext_sync && !ext_d_reg;
  wire       ext_fall = !ext_sync && ext_d_reg;
  wire       tick0    = t0_run && src0 && (t0ctrl_reg.cs != `DTP_CS_STOP) &&
                        tap_hit(pre0_reg, t0_div(t0ctrl_reg.cs));
  wire       tick2_in = (t2ctrl_reg.cs == `DTP_CS_EXT_FALL) ? ext_fall :
                        (t2ctrl_reg.cs == `DTP_CS_EXT_RISE) ? ext_rise :
                        (t2ctrl_reg.cs == `DTP_CS_STOP) ? 1'b0 :
                        tap_hit(pre2_reg, t2_div(t2ctrl_reg.cs));
  wire       tick2    = t2_run && tick2_in;

  // Timers.
  logic [7:0] cnt0;
  logic [7:0] cnt2;
  logic       ovf0;
  logic       ovf2;
  logic       match0;
  logic       match2;
  logic       pin0;
  logic       pin2;
  dtp_timer8 u_timer0 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .ctrl      (t0ctrl_reg),
    .cmp_val   (cmp0_reg),
    .tick      (tick0),
    .cnt_wr    (wr_cnt0),
    .cnt_wdata (w_data_reg),
    .cnt_reg   (cnt0),
    .pin_reg   (pin0),
    .ovf       (ovf0),
    .match     (match0)
  );
  dtp_timer8 u_timer2 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .ctrl      (t2ctrl_reg),
    .cmp_val   (cmp2_reg),
    .tick      (tick2),
    .cnt_wr    (wr_cnt2),
    .cnt_wdata (w_data_reg),
    .cnt_reg   (cnt2),
    .pin_reg   (pin2),
    .ovf       (ovf2),
    .match     (match2)
  );
  assign compare_out_pin_0 = pin0;
  assign compare_out_pin_2 = pin2;
  assign sleeping          = state_reg[1];

  // Flags: a new event beats a clear in the same cycle.
  wire [7:0] flag_set = {match2, ovf2, 4'h0, match0, ovf0};
  wire [7:0] flag_clr = (wr_flag ? w_data_reg : 8'h00) | (rd_flag ? flag_reg : 8'h00);
  assign flag_next = (flag_reg & ~flag_clr) | flag_set;
  wire [7:0] t0_mask = (8'h01 << `DTP_BIT_OVF0) | (8'h01 << `DTP_BIT_CMP0);
  wire       evt_any = |(flag_set & mask_reg);
  wire       evt_t0  = |(flag_set & mask_reg & t0_mask);

  // Sleep and wake sequencing.
  always_comb begin
    state_next    = state_reg;
    hide_cnt_next = hide_cnt_reg;
    unique case (state_reg)
      DTP_ST_RUN: begin
        if (wr_sleep && w_data_reg[`DTP_BIT_SLEEP_ENTER]) begin
          state_next = DTP_ST_SLEEP;
        end
      end
      DTP_ST_SLEEP: begin
        if (!sleep_mode_select_reg[1] && (wake_sync || evt_any)) begin
          state_next = DTP_ST_RUN;
        end else if (wake_sync) begin
          state_next    = DTP_ST_HIDE;
          hide_cnt_next = `DTP_WAKE_EXT_CYC;
        end else if (psave && async_sel_reg && evt_t0) begin
          state_next    = DTP_ST_HIDE;
          hide_cnt_next = `DTP_WAKE_TMR_CYC;
        end
      end
      DTP_ST_HIDE: begin
        hide_cnt_next = hide_cnt_reg - 2'h1;
        if (hide_cnt_reg == 2'h1) begin
          state_next = DTP_ST_RUN;
        end
      end
    endcase
  end

  // Read data selection.
  wire [7:0] rd_byte =
    (ar_idx == `DTP_IDX_CMP2)   ? cmp2_reg :
    (ar_idx == `DTP_IDX_CNT2)   ? cnt2 :
    (ar_idx == `DTP_IDX_T2CTRL) ? (t2ctrl_reg & `DTP_CTRL_WMASK) :
    (ar_idx == `DTP_IDX_ASYNC)  ? {7'h00, async_sel_reg} :
    (ar_idx == `DTP_IDX_CMP0)   ? cmp0_reg :
    (ar_idx == `DTP_IDX_CNT0)   ? cnt0 :
    (ar_idx == `DTP_IDX_T0CTRL) ? (t0ctrl_reg & `DTP_CTRL_WMASK) :
    (ar_idx == `DTP_IDX_SLEEP)  ? {sleeping, 5'h00, sleep_mode_select_reg} :
    (ar_idx == `DTP_IDX_FLAG)   ? (visible ? flag_reg : 8'h00) :
    (ar_idx == `DTP_IDX_MASK)   ? mask_reg : 8'h00;

  // Bus handshakes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      aw_idx_reg    <= 6'h00;
      w_have_reg    <= 1'b0;
      w_data_reg    <= 8'h00;
      w_lane_reg    <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DTP_RESP_OKAY;
    end else if (ce) begin
      aw_have_reg   <= aw_have_next;
      w_have_reg    <= w_have_next;
      s_axi_awready <= !aw_have_next && !bvalid_next;
      s_axi_wready  <= !w_have_next && !bvalid_next;
      s_axi_bvalid  <= bvalid_next;
      if (aw_take) begin
        aw_idx_reg <= (s_axi_awaddr[1:0] == 2'h0) ? s_axi_awaddr[7:2] : 6'h00;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        s_axi_bresp <= is_mapped(aw_idx_reg) ? `DTP_RESP_OKAY : `DTP_RESP_SLVERR;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DTP_RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, ar_ok ? rd_byte : 8'h00};
        s_axi_rresp   <= ar_ok ? `DTP_RESP_OKAY : `DTP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
      end
    end
  end

  // Registers, prescalers and sleep state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t0ctrl_reg            <= `DTP_REG_RST;
      t2ctrl_reg            <= `DTP_REG_RST;
      cmp0_reg              <= `DTP_REG_RST;
      cmp2_reg              <= `DTP_REG_RST;
      mask_reg              <= `DTP_REG_RST;
      flag_reg              <= `DTP_REG_RST;
      async_sel_reg         <= 1'b0;
      sleep_mode_select_reg <= 2'h0;
      state_reg             <= DTP_ST_RUN;
      hide_cnt_reg          <= 2'h0;
      pre0_reg              <= 10'h000;
      pre2_reg              <= 10'h000;
      osc_d_reg             <= 1'b0;
      ext_d_reg             <= 1'b0;
      irq                   <= 1'b0;
      wake_pulse            <= 1'b0;
    end else if (ce) begin
      if (wr_t0ctrl) t0ctrl_reg <= w_data_reg & `DTP_CTRL_WMASK;
      if (wr_t2ctrl) t2ctrl_reg <= w_data_reg & `DTP_CTRL_WMASK;
      if (wr_ok && aw_idx_reg == `DTP_IDX_CMP0) cmp0_reg <= w_data_reg;
      if (wr_ok && aw_idx_reg == `DTP_IDX_CMP2) cmp2_reg <= w_data_reg;
      if (wr_ok && aw_idx_reg == `DTP_IDX_MASK) mask_reg <= w_data_reg;
      if (wr_ok && aw_idx_reg == `DTP_IDX_ASYNC) async_sel_reg <= w_data_reg[`DTP_BIT_ASYNC_SEL];
      if (wr_sleep) sleep_mode_select_reg <= w_data_reg[1:0];
      flag_reg     <= flag_next;
      state_reg    <= state_next;
      hide_cnt_reg <= hide_cnt_next;
      osc_d_reg    <= osc_sync;
      ext_d_reg    <= ext_sync;
      if (t0_run && src0) pre0_reg <= pre0_reg + 10'h001;
      if (t2_run) pre2_reg <= pre2_reg + 10'h001;
      irq        <= (state_next != DTP_ST_HIDE) && |(flag_next & mask_reg);
      wake_pulse <= (state_reg == DTP_ST_SLEEP) && (state_next != DTP_ST_SLEEP);
    end
  end
endmodule // dtp_top

// ### tb/dtp_chk.sv
// Port checker for the dual 8-bit timer block, bound to its top module.
// Assumes ce stays high, so the bus handshakes advance on every clock.
`timescale 1ns/100ps
module dtp_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  // System
  input wire logic        wake_pulse,
  input wire logic        sleeping
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_rd_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  a_wr_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted");
  a_ctrl_top_zero: assert property (rd_take ##0 s_axi_araddr == 8'hcc |=> !s_axi_rdata[7])
    else $error("control top bit set");
  a_unmapped_rd: assert property (rd_take ##0 s_axi_araddr == 8'h00 |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read lanes set");
  a_wake_one: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse too long");
  a_wake_awake: assert property (wake_pulse |-> !sleeping)
    else $error("wake while sleeping");
endmodule // dtp_chk
bind dtp_top dtp_chk chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .wake_pulse, .sleeping);

// ### tb/dtp_partner.sv
// Far side of the timer block: crystal, external count source and wake source.
// Assumes the bench calls its tasks from the main sequence.
`timescale 1ns/100ps
module dtp_partner #(
  parameter int OSC_HALF = 165
) (
  // Pins toward the block
  output logic osc_pin,
  output logic count_pin,
  output logic wake_pin
);
  // The crystal runs free; it is much faster than a watch crystal to keep runs short.
  initial osc_pin = 1'b0;
  always #(OSC_HALF) osc_pin = ~osc_pin;
  initial count_pin = 1'b0;
  initial wake_pin = 1'b0;
  // Each level lasts three CPU periods, so every edge is sampled.
  task automatic edges(input int n);
    repeat (n) begin
      #300 count_pin = 1'b1;
      #300 count_pin = 1'b0;
    end
  endtask
  task automatic wake(input logic v);
    wake_pin = v;
  endtask
endmodule // dtp_partner

// ### tb/test_dual_8bit_timer_prescaler.sv
// Self-checking bench for the dual 8-bit timer block.
// Assumes the far-side model drives the pins and ce stays high.
`timescale 1ns/100ps
`include "dtp_params.svh"
module test_dual_8bit_timer_prescaler;
  localparam logic [7:0] adr_k2 = {`DTP_IDX_CMP2, 2'h0};
  localparam logic [7:0] adr_n2 = {`DTP_IDX_CNT2, 2'h0};
  localparam logic [7:0] adr_c2 = {`DTP_IDX_T2CTRL, 2'h0};
  localparam logic [7:0] adr_as = {`DTP_IDX_ASYNC, 2'h0};
  localparam logic [7:0] adr_k0 = {`DTP_IDX_CMP0, 2'h0};
  localparam logic [7:0] adr_n0 = {`DTP_IDX_CNT0, 2'h0};
  localparam logic [7:0] adr_c0 = {`DTP_IDX_T0CTRL, 2'h0};
  localparam logic [7:0] adr_sl = {`DTP_IDX_SLEEP, 2'h0};
  localparam logic [7:0] adr_fl = {`DTP_IDX_FLAG, 2'h0};
  localparam logic [7:0] adr_mk = {`DTP_IDX_MASK, 2'h0};
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        osc, cnt, wk, compare_out_pin_0, compare_out_pin_2, irq, wake_pulse, sleeping;
  logic [31:0] seed = 32'h11c2cea8;
  logic [15:0] notes[$], nt;
  logic [7:0]  c;
  logic        p;
  int          i, k, fail_count = 0, num_checks = 0;
  int unsigned dv[7] = '{1, 8, 32, 64, 128, 256, 1024};
  dtp_top dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .async_osc_in_pin(osc), .ext_count_pin(cnt),
    .ext_wake_pin(wk), .compare_out_pin_0, .compare_out_pin_2, .irq, .wake_pulse, .sleeping);
  dtp_partner #(.OSC_HALF(165)) pt (.osc_pin(osc), .count_pin(cnt), .wake_pin(wk));
  always #50 aclk = ~aclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] t,
                     input logic [7:0] g);
    logic [7:0] d;
    d = g - e;
    num_checks++;
    if ((^g === 1'bx) || (d > t && 8'h0 - d > t)) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      nt = notes.pop_front();
      chk("rdata", nt[7:0], nt[15:8], s_axi_rdata[7:0]);
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 100);
    if (n >= 100) fail_count++;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] t);
    int n;
    n = 0;
    notes.push_back({t, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 100);
    if (n >= 100) fail_count++;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_wake();
    k = 0;
    while (!wake_pulse && k < 3000) begin
      @(posedge aclk);
      k++;
    end
    chk("wake", 8'h1, 8'h0, {7'h0, wake_pulse});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(adr_c0, 8'h00, 8'h0);
    rd(adr_fl, 8'h00, 8'h0);
    wr(adr_c0, 8'hff);
    rd(adr_c0, 8'h7f, 8'h0);
    rd(8'h00, 8'h00, 8'h0);
    $display("test registers done");
    // Eight runs of 2000 cycles: each divider on the CPU clock, then the crystal undivided.
    for (i = 1; i < 9; i++) begin
      wr(adr_as, {7'h0, i == 8});
      wr(adr_c0, 8'h00);
      wr(adr_n0, 8'h00);
      wr(adr_c0, (i == 8) ? 8'h01 : i[7:0]);
      repeat (2000) @(posedge aclk);
      wr(adr_c0, 8'h00);
      rd(adr_n0, 8'((i == 8) ? 200500 / 330 : 2005 / dv[i - 1]), 8'h4);
    end
    $display("test prescaler done");
    seed = lfsr(seed);
    wr(adr_as, 8'h00);
    wr(adr_k2, {1'b0, seed[6:0]} + 8'h20);
    rd(adr_fl, 8'h00, 8'hff);
    wr(adr_c2, 8'h09);
    repeat (600) @(posedge aclk);
    wr(adr_c2, 8'h00);
    wr(adr_mk, 8'h80);
    @(posedge aclk);
    chk("irq", 8'h1, 8'h0, {7'h0, irq});
    rd(adr_fl, 8'h80, 8'h0);
    repeat (2) @(posedge aclk);
    chk("irq", 8'h0, 8'h0, {7'h0, irq});
    wr(adr_mk, 8'h00);
    $display("test clear on match done");
    for (i = 6; i < 8; i++) begin
      seed = lfsr(seed);
      wr(adr_n2, 8'h00);
      wr(adr_c2, i[7:0]);
      pt.edges(seed[3:0] + 1);
      repeat (10) @(posedge aclk);
      rd(adr_n2, {4'h0, seed[3:0]} + 8'h1, 8'h0);
      wr(adr_c2, 8'h00);
    end
    $display("test external count done");
    // Compare modes set, clear, toggle and off, with the counter cleared at 0x10.
    wr(adr_k0, 8'h10);
    // Start from zero so the first mode sees a match inside its window.
    wr(adr_n0, 8'h00);
    for (i = 3; i >= 0; i--) begin
      wr(adr_c0, {2'h0, i[1:0], 4'h9});
      repeat (40) @(posedge aclk);
      k = 0;
      p = compare_out_pin_0;
      repeat (68) begin
        @(posedge aclk);
        if (compare_out_pin_0 !== p) k++;
        p = compare_out_pin_0;
      end
      chk("toggles", (i == 1) ? 8'h4 : 8'h0, {7'h0, i == 1}, k[7:0]);
      if (i > 1) chk("pin", {7'h0, i[0]}, 8'h0, {7'h0, p});
    end
    wr(adr_c0, 8'h00);
    seed = lfsr(seed);
    c = {1'b0, seed[6:0]} + 8'h20;
    wr(adr_k2, c);
    wr(adr_c2, 8'h61);
    repeat (600) @(posedge aclk);
    k = 0;
    repeat (1020) begin
      @(posedge aclk);
      k += compare_out_pin_2;
    end
    chk("pwm", c, 8'h2, 8'(k / 4));
    wr(adr_c2, 8'h00);
    $display("test compare output done");
    wr(adr_as, 8'h01);
    wr(adr_k0, 8'h80);
    wr(adr_n0, 8'hf0);
    wr(adr_mk, 8'h01);
    rd(adr_fl, 8'h00, 8'hff);
    wr(adr_sl, 8'h83);
    wr(adr_c0, 8'h01);
    wait_wake();
    repeat (8) @(posedge aclk);
    chk("irq", 8'h1, 8'h0, {7'h0, irq});
    rd(adr_fl, 8'h01, 8'h0);
    wr(adr_c0, 8'h00);
    wr(adr_sl, 8'h82);
    chk("sleeping", 8'h1, 8'h0, {7'h0, sleeping});
    pt.wake(1'b1);
    wait_wake();
    pt.wake(1'b0);
    $display("test sleep done");
    summarize();
  end
endmodule // test_dual_8bit_timer_prescaler
